/* logic/image_pipe_input_pkg.sv */
package image_pipe_input_pkg;

  // Register byte offsets
  localparam logic [7:0] ENABLE_OFS = 8'h00;
  localparam logic [7:0] CONFIG_1_OFS = 8'h04;
  localparam logic [7:0] HSYNC_INTERVAL_OFS = 8'h08;
  localparam logic [7:0] VSYNC_INTERVAL_OFS = 8'h0c;
  localparam logic [7:0] VALID_PIXELS_OFS = 8'h10;
  localparam logic [7:0] VALID_LINES_OFS = 8'h14;
  localparam logic [7:0] MEM_ADDRESS_UPPER_OFS = 8'h18;
  localparam logic [7:0] MEM_ADDRESS_LOWER_OFS = 8'h1c;
  localparam logic [7:0] LINE_ADDRESS_OFFSET_OFS = 8'h20;
  localparam logic [7:0] HORIZONTAL_RESIZE_OFS = 8'h24;
  localparam logic [7:0] OUTPUT_GAIN_OFS = 8'h28;
  localparam logic [7:0] PREDICTIVE_CODING_OFS = 8'h2c;
  localparam logic [7:0] CONFIG_2_OFS = 8'h30;
  localparam logic [7:0] RESIZE_INITIAL_OFS = 8'h34;
  localparam logic [7:0] OUTPUT_CLIP_OFS = 8'h38;
  localparam logic [7:0] UNDERFLOW_STATUS_OFS = 8'h3c;
  localparam logic [7:0] CLOCK_RATE_OFS = 8'h40;
  localparam logic [7:0] DEFECT_CORRECTION_1_OFS = 8'h44;
  localparam logic [7:0] DEFECT_CORRECTION_2_OFS = 8'h48;
  localparam logic [7:0] STATS_RESIZE_OFS = 8'h54;
  localparam logic [7:0] STATS_RESIZE_INITIAL_OFS = 8'h58;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h5c;

  localparam int NUM_REGS = 24;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Field positions
  localparam int RUN_BIT = 0;
  localparam int VSYNC_MASK_BIT = 1;
  localparam int SRC_LSB = 14;
  localparam int SHIFT_LSB = 11;
  localparam int CLK_SEL_BIT = 10;
  localparam int SINGLE_RUN_BIT = 0;
  localparam int UNDERFLOW_BIT = 0;
  localparam int FRAME_DONE_BIT = 1;

  // Input source encodings
  localparam logic [1:0] SRC_PARALLEL = 2'h0;
  localparam logic [1:0] SRC_MEM_RAW = 2'h1;
  localparam logic [1:0] SRC_DARK_FRAME = 2'h2;
  localparam logic [1:0] SRC_MEM_YUV = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [NUM_REGS-1:0][31:0] regs;
    logic [7:0] div;
    logic [12:0] h;
    logic [12:0] v;
    logic [13:0] pix;
    logic pix_vld;
    logic hs;
    logic vs;
    logic req;
    logic [31:0] rdata;
    logic irq;
  } state_t;

endpackage

/* logic/image_pipe_input_interface.sv */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module image_pipe_input_interface (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire image_pipe_input_pkg::reg_req_t reg_req_i,
  output logic [31:0] rdata_o,
  // Parallel capture port
  input wire logic [13:0] par_data_i,
  input wire logic par_valid_i,
  input wire logic par_hsync_i,
  input wire logic par_vsync_i,
  // Memory read port
  input wire logic [15:0] mem_data_i,
  input wire logic mem_valid_i,
  output logic mem_req_o,
  // Pipeline output
  output logic [13:0] pix_o,
  output logic pix_valid_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic pipe_clock_select_o,
  output logic [6:0] stats_resize_o,
  output logic [12:0] stats_resize_start_o,
  // Interrupt
  output logic irq_o
);

  image_pipe_input_pkg::state_t q;
  image_pipe_input_pkg::state_t d;

  logic [4:0] idx_w;
  logic [1:0] src_w;
  logic [2:0] shift_w;
  logic running_w;
  logic div_tick_w;
  logic tick_w;
  logic active_w;
  logic fire_w;
  logic frame_end_w;
  logic single_w;
  logic [31:0] clr_w;
  logic [31:0] evt_w;
  logic [13:0] mem_pix_w;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= image_pipe_input_pkg::IRQ_MASK_OFS)
      && (a != 8'h4c) && (a != 8'h50);
  endfunction

  // Writable bits per register; reserved bits stay zero
  function automatic logic [31:0] wmask(input logic [4:0] i);
    unique case (i)
      5'h00: wmask = 32'h0000_0003;
      5'h01: wmask = 32'h0000_ff8f;
      5'h02, 5'h03, 5'h04, 5'h05: wmask = 32'h0000_1fff;
      5'h06: wmask = 32'h0000_07ff;
      5'h08: wmask = 32'h0000_01ff;
      5'h09, 5'h15: wmask = 32'h0000_007f;
      5'h0a: wmask = 32'h0000_03ff;
      5'h0b: wmask = 32'h0000_0007;
      5'h0f: wmask = 32'h0000_0003;
      5'h17: wmask = 32'h0000_0003;
      default: wmask = 32'h0000_ffff;
    endcase
  endfunction

  // Read word shaping; value 7 takes the top bits instead of a left shift
  function automatic logic [13:0] shape(input logic [1:0] s,
                                        input logic [2:0] n,
                                        input logic [15:0] w);
    if (s == image_pipe_input_pkg::SRC_MEM_RAW ||
        s == image_pipe_input_pkg::SRC_DARK_FRAME) begin
      if (n == 3'h7) begin
        shape = w[15:2];
      end else begin
        shape = w[13:0] << n;
      end
    end else begin
      shape = w[13:0];
    end
  endfunction

  assign idx_w = reg_req_i.addr[6:2];
  assign src_w = q.regs[1][image_pipe_input_pkg::SRC_LSB +: 2];
  assign shift_w = q.regs[1][image_pipe_input_pkg::SHIFT_LSB +: 3];
  assign running_w = q.regs[0][image_pipe_input_pkg::RUN_BIT] &&
    (src_w != image_pipe_input_pkg::SRC_PARALLEL);
  assign div_tick_w = (q.div == q.regs[16][7:0]);
  assign tick_w = q.regs[1][image_pipe_input_pkg::CLK_SEL_BIT] ?
    div_tick_w : par_valid_i;
  assign active_w = (q.h < q.regs[4][12:0]) && (q.v < q.regs[5][12:0]);
  assign fire_w = running_w && tick_w && active_w;
  assign frame_end_w = running_w && tick_w &&
    (q.h == q.regs[2][12:0]) && (q.v == q.regs[3][12:0]);
  assign single_w = q.regs[1][image_pipe_input_pkg::SINGLE_RUN_BIT] &&
    (src_w == image_pipe_input_pkg::SRC_MEM_RAW ||
     src_w == image_pipe_input_pkg::SRC_MEM_YUV);
  assign mem_pix_w = shape(src_w, shift_w, mem_data_i);

  always_comb begin
    clr_w = '0;
    evt_w = '0;
    d = q;
    d.div = div_tick_w ? 8'h00 : q.div + 8'h01;
    d.hs = 1'b0;
    d.vs = 1'b0;
    d.req = 1'b0;
    d.pix_vld = 1'b0;
    d.rdata = '0;
    // Pixel generation
    if (!running_w) begin
      d.h = '0;
      d.v = '0;
      if (src_w == image_pipe_input_pkg::SRC_PARALLEL) begin
        d.pix = par_data_i;
        d.pix_vld = par_valid_i;
        d.hs = par_hsync_i;
        d.vs = par_vsync_i &&
          !q.regs[0][image_pipe_input_pkg::VSYNC_MASK_BIT];
      end
    end else if (tick_w) begin
      d.hs = (q.h == 13'h0000);
      d.vs = (q.h == 13'h0000) && (q.v == 13'h0000) &&
        !q.regs[0][image_pipe_input_pkg::VSYNC_MASK_BIT];
      if (q.h == q.regs[2][12:0]) begin
        d.h = '0;
        d.v = (q.v == q.regs[3][12:0]) ? 13'h0000 : q.v + 13'h0001;
      end else begin
        d.h = q.h + 13'h0001;
      end
      if (active_w) begin
        d.req = 1'b1;
        d.pix_vld = mem_valid_i;
        if (src_w == image_pipe_input_pkg::SRC_DARK_FRAME) begin
          // Dark frame removal clamps at black instead of wrapping
          d.pix = (par_data_i > mem_pix_w) ? par_data_i - mem_pix_w
                                           : 14'h0000;
        end else begin
          d.pix = mem_pix_w;
        end
        // Data not ready when the pipeline needs it
        evt_w[image_pipe_input_pkg::UNDERFLOW_BIT] = !mem_valid_i;
      end
      if (frame_end_w) begin
        evt_w[image_pipe_input_pkg::FRAME_DONE_BIT] = 1'b1;
        if (single_w) begin
          d.regs[0][image_pipe_input_pkg::RUN_BIT] = 1'b0;
        end
      end
    end
    // Register writes; software write after hardware stop wins
    if (reg_req_i.wr && mapped(reg_req_i.addr)) begin
      if (reg_req_i.addr == image_pipe_input_pkg::UNDERFLOW_STATUS_OFS) begin
        clr_w = reg_req_i.wdata;
      end else begin
        d.regs[idx_w] = reg_req_i.wdata & wmask(idx_w);
      end
    end
    // Set wins over write-one-to-clear
    d.regs[15] = ((q.regs[15] & ~clr_w) | evt_w) & wmask(5'h0f);
    if (reg_req_i.rd && mapped(reg_req_i.addr)) begin
      d.rdata = q.regs[idx_w];
    end
    d.irq = |(d.regs[15] & d.regs[23]);
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign mem_req_o = q.req;
  assign pix_o = q.pix;
  assign pix_valid_o = q.pix_vld;
  assign hsync_o = q.hs;
  assign vsync_o = q.vs;
  assign pipe_clock_select_o = q.regs[1][image_pipe_input_pkg::CLK_SEL_BIT];
  assign stats_resize_o = q.regs[21][6:0];
  assign stats_resize_start_o = q.regs[22][12:0];
  assign irq_o = q.irq;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  idle_no_req_a: assert property (
    !q.regs[0][image_pipe_input_pkg::RUN_BIT] |=> !mem_req_o)
    else $error("memory request while run bit clear");

  src_zero_idle_a: assert property (
    src_w == image_pipe_input_pkg::SRC_PARALLEL |=> !mem_req_o)
    else $error("memory request with parallel source");

  vsync_masked_a: assert property (
    q.regs[0][image_pipe_input_pkg::VSYNC_MASK_BIT] |=> !vsync_o)
    else $error("vsync passed while masked");

  shift_raw_a: assert property (
    fire_w && src_w == image_pipe_input_pkg::SRC_MEM_RAW && shift_w != 3'h7
    |=> pix_o == 14'($past(mem_data_i[13:0]) << $past(shift_w)))
    else $error("read shift result wrong");

  shift_seven_a: assert property (
    fire_w && src_w == image_pipe_input_pkg::SRC_MEM_RAW && shift_w == 3'h7
    |=> pix_o == $past(mem_data_i[15:2]))
    else $error("shift seven result wrong");

  yuv_unshifted_a: assert property (
    fire_w && src_w == image_pipe_input_pkg::SRC_MEM_YUV
    |=> pix_o == $past(mem_data_i[13:0]))
    else $error("shift applied to yuv data");

  // Set wins, so a clear in the same cycle cannot hide the event
  underflow_flag_a: assert property (
    fire_w && !mem_valid_i
    |=> q.regs[15][image_pipe_input_pkg::UNDERFLOW_BIT])
    else $error("underflow not recorded");

  irq_level_a: assert property (
    irq_o ==
    |(q.regs[15] & q.regs[23]))
    else $error("interrupt level differs from masked status");

  underflow_no_pix_a: assert property (
    fire_w && !mem_valid_i
    |=> !pix_valid_o)
    else $error("pixel marked valid without memory data");

  status_clear_a: assert property (
    reg_req_i.wr && reg_req_i.addr == image_pipe_input_pkg::UNDERFLOW_STATUS_OFS
    && reg_req_i.wdata[0] && !evt_w[image_pipe_input_pkg::UNDERFLOW_BIT]
    |=> !q.regs[15][image_pipe_input_pkg::UNDERFLOW_BIT])
    else $error("underflow flag not cleared");

  status_rsvd_a: assert property (
    q.regs[15][31:2] ==
    30'h0000_0000)
    else $error("status reserved bits set");

  single_stop_a: assert property (
    frame_end_w && single_w && !reg_req_i.wr
    |=> !q.regs[0][image_pipe_input_pkg::RUN_BIT] ##1 !mem_req_o)
    else $error("single run did not stop");

  pace_a: assert property (
    running_w && !tick_w |=> !mem_req_o && !hsync_o)
    else $error("pipeline advanced without a pace tick");

  stats_write_a: assert property (
    reg_req_i.wr && reg_req_i.addr == image_pipe_input_pkg::STATS_RESIZE_OFS
    |=> stats_resize_o == $past(reg_req_i.wdata[6:0]))
    else $error("statistics resize not stored");

  stats_start_a: assert property (
    reg_req_i.wr && reg_req_i.addr == image_pipe_input_pkg::STATS_RESIZE_INITIAL_OFS
    |=> stats_resize_start_o == $past(reg_req_i.wdata[12:0]))
    else $error("statistics resize start not stored");

  // Pixel slot handshake toward memory
  pix_valid_a: assert property (
    fire_w && mem_valid_i
    |=> pix_valid_o)
    else $error("pixel not marked valid");

  req_fire_a: assert property (
    fire_w
    |=> mem_req_o)
    else $error("memory request missing for active pixel");

  req_only_fire_a: assert property (
    !fire_w
    |=> !mem_req_o)
    else $error("memory request outside an active pixel");

  hsync_line_a: assert property (
    running_w && tick_w && q.h == 13'h0000
    |=> hsync_o)
    else $error("line start without hsync");

  hsync_only_start_a: assert property (
    running_w && tick_w && q.h != 13'h0000
    |=> !hsync_o)
    else $error("hsync in mid line");

  idle_counters_a: assert property (
    !running_w
    |=> q.h == 13'h0000 && q.v == 13'h0000)
    else $error("position counters moved while idle");

  // Sync outputs and source selection
  vsync_frame_a: assert property (
    running_w && tick_w && q.h == 13'h0000 && q.v == 13'h0000 &&
    !q.regs[0][image_pipe_input_pkg::VSYNC_MASK_BIT] |=> vsync_o)
    else $error("frame start without vsync");

  par_vsync_a: assert property (
    !running_w && src_w == image_pipe_input_pkg::SRC_PARALLEL && par_vsync_i &&
    !q.regs[0][image_pipe_input_pkg::VSYNC_MASK_BIT] |=> vsync_o)
    else $error("parallel vsync not passed");

  par_pass_a: assert property (
    !running_w && src_w == image_pipe_input_pkg::SRC_PARALLEL
    |=> pix_o == $past(par_data_i) && pix_valid_o == $past(par_valid_i))
    else $error("parallel pixel not passed");

  dark_clamp_a: assert property (
    fire_w && src_w == image_pipe_input_pkg::SRC_DARK_FRAME
    |=> pix_o <= $past(par_data_i))
    else $error("dark frame result above live pixel");

  // Pacing
  div_restart_a: assert property (
    div_tick_w
    |=> q.div == 8'h00)
    else $error("divider did not restart");

  pixel_pace_a: assert property (
    running_w && !q.regs[1][image_pipe_input_pkg::CLK_SEL_BIT] && !par_valid_i
    |=> !pix_valid_o)
    else $error("pixel without pixel clock pace");

  divided_pace_a: assert property (
    running_w && q.regs[1][image_pipe_input_pkg::CLK_SEL_BIT] && !div_tick_w
    |=> !mem_req_o)
    else $error("memory read without divider tick");

  single_keep_a: assert property (
    frame_end_w && !single_w && !reg_req_i.wr
    |=> q.regs[0][image_pipe_input_pkg::RUN_BIT])
    else $error("continuous mode stopped at frame end");

  // Register bus hygiene
  enable_rsvd_a: assert property (
    q.regs[0][31:2] ==
    30'h0000_0000)
    else $error("enable reserved bits stored");

  config_rsvd_a: assert property (
    q.regs[1][31:16] == 16'h0000 &&
    q.regs[1][6:4] == 3'h0)
    else $error("config reserved bits stored");

  rd_unmapped_a: assert property (
    reg_req_i.rd && !mapped(reg_req_i.addr)
    |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read returned data");

  rd_gap_a: assert property (
    !reg_req_i.rd
    |=> rdata_o == 32'h0000_0000)
    else $error("read data held past its cycle");

  frame_done_c: cover property (frame_end_w ##1 irq_o);
  dark_frame_c: cover property (
    fire_w && src_w == image_pipe_input_pkg::SRC_DARK_FRAME);
  underflow_c: cover property (fire_w && !mem_valid_i);
  single_run_c: cover property (frame_end_w && single_w);

endmodule

/* dv/mem_buffer_model.sv */
`timescale 1ns/1ps
module mem_buffer_model (
  // Clock
  input wire logic clk_sys_i,
  // Bench control
  input wire logic [15:0] word_i,
  input wire logic starve_i,
  // Toward the block
  input wire logic mem_req_i,
  output logic [15:0] mem_data_o,
  output logic mem_valid_o
);
  logic [15:0] last_q = 16'h0;

  // Starved bus shows inverted data, so a stale word never matches
  assign mem_valid_o = !starve_i;
  assign mem_data_o = starve_i ? ~last_q : word_i;

  always_ff @(posedge clk_sys_i) begin
    if (mem_req_i) begin
      last_q <= word_i;
    end
  end
endmodule

/* dv/image_pipe_input_interface_test.sv */
`timescale 1ns/1ps
module image_pipe_input_interface_test;
  typedef struct packed {
    logic [1:0] src;
    logic [2:0] n;
    logic [15:0] w;
    logic [13:0] par;
    logic [13:0] pix;
  } row_t;

  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  image_pipe_input_pkg::reg_req_t req_q = '0;
  logic [13:0] par_q = 14'h0;
  logic [15:0] word_q = 16'h0;
  logic starve_q = 1'b0;
  logic [31:0] rdata_o, d;
  logic [15:0] mem_data;
  logic mem_valid, mem_req_o, pix_valid_o, hsync_o, vsync_o, irq_o, clk_sel;
  logic [13:0] pix_o;
  logic [6:0] horizontal_resize_param;
  logic [12:0] rsz_start;
  int err_total = 0;
  int n_checks = 0;
  int c;
  row_t rows [7] = '{
    '{2'h1, 3'h0, 16'hc123, 14'h0, 14'h0123},
    '{2'h1, 3'h3, 16'h0123, 14'h0, 14'h0918},
    '{2'h1, 3'h6, 16'h00ff, 14'h0, 14'h3fc0},
    '{2'h1, 3'h7, 16'hc123, 14'h0, 14'h3048},
    '{2'h3, 3'h5, 16'hc123, 14'h0, 14'h0123},
    '{2'h2, 3'h1, 16'h0010, 14'h0100, 14'h00e0},
    '{2'h2, 3'h0, 16'h0200, 14'h0100, 14'h0000}
  };

  always #10 clk_sys_i = ~clk_sys_i;

  image_pipe_input_interface dut_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_req_i(req_q),
    .rdata_o(rdata_o), .par_data_i(par_q), .par_valid_i(1'b1),
    .par_hsync_i(1'b0), .par_vsync_i(1'b0), .mem_data_i(mem_data),
    .mem_valid_i(mem_valid), .mem_req_o(mem_req_o), .pix_o(pix_o),
    .pix_valid_o(pix_valid_o), .hsync_o(hsync_o), .vsync_o(vsync_o),
    .pipe_clock_select_o(clk_sel), .stats_resize_o(horizontal_resize_param),
    .stats_resize_start_o(rsz_start), .irq_o(irq_o)
  );

  mem_buffer_model mem_u (
    .clk_sys_i(clk_sys_i), .word_i(word_q), .starve_i(starve_q),
    .mem_req_i(mem_req_o), .mem_data_o(mem_data), .mem_valid_o(mem_valid)
  );

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    req_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys_i);
    req_q <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    req_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys_i);
    req_q <= '0;
    #1 v = rdata_o;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Bounded wait: cycles until the next pixel pulse, 50 means none
  task automatic wait_pix(output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (pix_valid_o !== 1'b1 && k < 50);
  endtask

  task automatic quiet(output int k);
    k = 0;
    repeat (20) begin
      tick(1);
      k += int'(mem_req_o === 1'b1);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100us;
    err_total++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(image_pipe_input_pkg::CONFIG_1_OFS, d);
    chk(d, 32'h0);
    // Reserved bits written on purpose: they must not stick
    wr(image_pipe_input_pkg::CONFIG_1_OFS, 32'hffff_ffff);
    rd(image_pipe_input_pkg::CONFIG_1_OFS, d);
    chk(d, 32'h0000_ff8f);
    rd(8'h4c, d);
    chk(d, 32'h0);
    wr(image_pipe_input_pkg::STATS_RESIZE_OFS, 32'h0000_00ff);
    wr(image_pipe_input_pkg::STATS_RESIZE_INITIAL_OFS, 32'h0000_ffff);
    tick(1);
    chk(32'({horizontal_resize_param, rsz_start}), 32'hfffff);
    rd(image_pipe_input_pkg::STATS_RESIZE_OFS, d);
    chk(d, 32'h0000_007f);
    tick(1);
    chk(rdata_o, 32'h0);
    wr(image_pipe_input_pkg::HSYNC_INTERVAL_OFS, 32'h3);
    wr(image_pipe_input_pkg::VSYNC_INTERVAL_OFS, 32'h1);
    wr(image_pipe_input_pkg::VALID_PIXELS_OFS, 32'h4);
    wr(image_pipe_input_pkg::VALID_LINES_OFS, 32'h2);
    foreach (rows[i]) begin
      wr(image_pipe_input_pkg::ENABLE_OFS, 32'h0);
      wr(image_pipe_input_pkg::CONFIG_1_OFS,
         {16'h0, rows[i].src, rows[i].n, 11'h0});
      word_q <= rows[i].w;
      par_q <= rows[i].par;
      wr(image_pipe_input_pkg::ENABLE_OFS, 32'h1);
      wait_pix(c);
      chk(32'(pix_o), 32'(rows[i].pix));
      chk(32'({pix_valid_o, hsync_o, vsync_o, mem_req_o}), 32'hf);
    end
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h0);
    wr(image_pipe_input_pkg::CONFIG_1_OFS, 32'h4000);
    quiet(c);
    chk(32'(c), 32'h0);
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h3);
    wait_pix(c);
    chk(32'({pix_valid_o, hsync_o, vsync_o}), 32'h6);
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h0);
    wr(image_pipe_input_pkg::CONFIG_1_OFS, 32'h0);
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h1);
    quiet(c);
    chk(32'(c), 32'h0);
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h0);
    wr(image_pipe_input_pkg::CLOCK_RATE_OFS, 32'h2);
    wr(image_pipe_input_pkg::CONFIG_1_OFS, 32'h4400);
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h1);
    chk(32'(clk_sel), 32'h1);
    wait_pix(c);
    wait_pix(c);
    chk(32'(c), 32'h3);
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h0);
    wr(image_pipe_input_pkg::UNDERFLOW_STATUS_OFS, 32'h3);
    wr(image_pipe_input_pkg::CONFIG_1_OFS, 32'h0401);
    wr(image_pipe_input_pkg::CLOCK_RATE_OFS, 32'h0);
    wr(image_pipe_input_pkg::CONFIG_1_OFS, 32'h4001);
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h1);
    tick(20);
    rd(image_pipe_input_pkg::ENABLE_OFS, d);
    chk(d, 32'h0);
    wr(image_pipe_input_pkg::UNDERFLOW_STATUS_OFS, 32'h3);
    wr(image_pipe_input_pkg::IRQ_MASK_OFS, 32'h1);
    wr(image_pipe_input_pkg::CONFIG_1_OFS, 32'h4000);
    starve_q <= 1'b1;
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h1);
    wr(image_pipe_input_pkg::ENABLE_OFS, 32'h0);
    starve_q <= 1'b0;
    rd(image_pipe_input_pkg::UNDERFLOW_STATUS_OFS, d);
    chk(d, 32'h1);
    chk(32'(irq_o), 32'h1);
    wr(image_pipe_input_pkg::IRQ_MASK_OFS, 32'h0);
    tick(2);
    chk(32'(irq_o), 32'h0);
    wr(image_pipe_input_pkg::IRQ_MASK_OFS, 32'h1);
    wr(image_pipe_input_pkg::UNDERFLOW_STATUS_OFS, 32'h1);
    tick(2);
    chk(32'(irq_o), 32'h0);
    finish_test();
  end
endmodule
